/* File: rtl/tlic_ctrl.sv */
// two-level interrupt controller: flags, gating, priority, polling and vector call
`timescale 1ns/1ps
// Functional notes
// - ext2..5 flags sticky, auto-clear select clears on entry
// - timer0/1 overflow flags cleared on vectoring
// - timer2 request ORs two flags, never hardware-cleared
// - watchdog flag requests only when its enable set
// - serial request ORs rx/tx done, software clears
// - software may set or clear every flag
// - per-source enables, global gate spares power-fail
// - two levels, high never preempted by low
// - fixed tie-break order within one level
// - poll each machine cycle, vector only when allowed
// - denied requests are not remembered
// - ext0/1 flag cleared on vectoring only edge-mode
// - call pushes pc, not status word, loads vector
// - fixed vector address per source
// - service exit ends level, plain return does not
// - pins sampled phase three, timer0/1 flags set then
// - call lasts four machine cycles, five minimum
// - latency at most twelve machine cycles idle
// - edge mode high-then-low sets, level follows low
module tlic_ctrl #(
    parameter logic [15:0] PFAIL_VECTOR = 16'h0033
) (
    // clock and reset
    input  wire logic        MCLK,
    input  wire logic        RSTN,
    // external request pins
    input  wire logic [5:0]  EXT_PIN,
    // peripheral events, one-clock pulses
    input  wire logic        TF0_OVF,
    input  wire logic        TF1_OVF,
    input  wire logic        TF2_OVF,
    input  wire logic        TIMER2_EXTERNAL_FLAG_EVT,
    input  wire logic        WD_TIMEOUT,
    input  wire logic        RX0_DONE,
    input  wire logic        TX0_DONE,
    input  wire logic        RX1_DONE,
    input  wire logic        TX1_DONE,
    input  wire logic        POWER_FAIL_REQ,
    // configuration
    input  wire logic [11:0] SRC_ENABLE,
    input  wire logic        GLOBAL_GATE,
    input  wire logic [11:0] PRIO_HIGH,
    input  wire logic        EXT0_EDGE,
    input  wire logic        EXT1_EDGE,
    input  wire logic [3:0]  AUTO_CLEAR,
    // software flag write
    input  wire logic        FLAG_WR,
    input  wire logic [3:0]  FLAG_SEL,
    input  wire logic        FLAG_VAL,
    // core sequencer status
    input  wire logic        LAST_CYCLE,
    input  wire logic        CFG_WRITE,
    input  wire logic        EXIT_OP,
    // outputs to the core
    output logic [1:0]       MC_PHASE,
    output logic             CALL_ACTIVE,
    output logic             PUSH_LOW,
    output logic             PUSH_HIGH,
    output logic             PC_LOAD,
    output logic [15:0]      VEC_ADDR,
    output logic             IN_SERVICE_HI,
    output logic             IN_SERVICE_LO,
    output logic [14:0]      FLAGS
);
    ////////////////////////////////////////////////////////////////////////////
    logic [1:0]            phase_q;
    logic [1:0]            call_mc_q;
    tlic_pkg::tlic_state_t state_q;
    logic                  call_act_q;
    logic                  push_lo_q;
    logic                  push_hi_q;
    logic                  pc_load_q;
    logic [15:0]           vec_q;
    logic [15:0]           vec_d;
    logic                  ins_hi_q;
    logic                  ins_lo_q;
    logic [5:0]            ext_flag;
    logic [8:0]            soft_q;

    wire        p_three;
    wire        p_last;
    wire        call_end;
    wire        may_vector;
    wire [11:0] req;
    wire [11:0] active;
    wire        any_hi;
    wire        any_lo;
    wire [3:0]  idx_hi;
    wire [3:0]  idx_lo;
    wire        pfi_take;
    wire        hi_take;
    wire        lo_take;
    wire        poll_take;
    wire [3:0]  sel;
    wire        sel_is_hi;
    wire        exit_now;
    wire [5:0]  ext_clr;
    wire [8:0]  soft_set;
    wire [8:0]  soft_clr;

    assign p_three  = (phase_q == tlic_pkg::PHASE_THREE);
    assign p_last   = (phase_q == tlic_pkg::PHASE_LAST);
    assign call_end = (state_q == tlic_pkg::ST_CALL) && p_last && (call_mc_q == tlic_pkg::CALL_MC_LAST);

    ////////////////////////////////////////////////////////////////////////////
    // external request flags
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_ext
            localparam logic [3:0] K = 4'(int'(tlic_pkg::FLG_EXT0) + g);
            tlic_ext_flag u_flag (
                .clk       (MCLK),
                .rst_n     (RSTN),
                .pin       (EXT_PIN[g]),
                .sample_en (p_three),
                .edge_mode ((g == 0) ? EXT0_EDGE : (g == 1) ? EXT1_EDGE : 1'b1),
                .hw_clear  (ext_clr[g]),
                .sw_wr     (FLAG_WR && (FLAG_SEL == K)),
                .sw_val    (FLAG_VAL),
                .flag_q    (ext_flag[g])
            );
        end
    endgenerate

    // level-mode flags are never touched by hardware on entry
    assign ext_clr[0] = poll_take && !pfi_take && (sel == tlic_pkg::SRC_EXT0) && EXT0_EDGE;
    assign ext_clr[1] = poll_take && !pfi_take && (sel == tlic_pkg::SRC_EXT1) && EXT1_EDGE;
    generate
        for (g = 0; g < 4; g++) begin : g_hc
            assign ext_clr[g+2] = poll_take && !pfi_take && AUTO_CLEAR[g]
                                && (sel == 4'(int'(tlic_pkg::SRC_EXT2) + g));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // peripheral flags; timer0/1 overflow only lands at phase three
    assign soft_set = {TX1_DONE, RX1_DONE, TX0_DONE, RX0_DONE, WD_TIMEOUT, TIMER2_EXTERNAL_FLAG_EVT, TF2_OVF,
                       TF1_OVF && p_three, TF0_OVF && p_three};
    assign soft_clr = {7'h00,
                       poll_take && !pfi_take && (sel == tlic_pkg::SRC_TF1),
                       poll_take && !pfi_take && (sel == tlic_pkg::SRC_TF0)};

    generate
        for (g = 0; g < tlic_pkg::NUM_SOFT; g++) begin : g_soft
            localparam logic [3:0] K = 4'(int'(tlic_pkg::FLG_TF0) + g);
            wire hit;
            assign hit = FLAG_WR && (FLAG_SEL == K);
            always_ff @(posedge MCLK or negedge RSTN) begin
                if (!RSTN) begin
                    soft_q[g] <= tlic_pkg::FLAG_RESET;
                end else begin
                    // set wins; serial, timer2 and watchdog flags clear only by write
                    soft_q[g] <= soft_set[g] | (hit ? FLAG_VAL : (soft_q[g] & ~soft_clr[g]));
                end
            end
        end
    endgenerate

    assign FLAGS = {soft_q, ext_flag};

    ////////////////////////////////////////////////////////////////////////////
    // request gating and priority resolution
    // soft_q order: tf0, tf1, tf2, timer2_external_flag, wd, rx0, tx0, rx1, tx1
    assign req = {soft_q[4],
                  ext_flag[5:2],
                  soft_q[7] | soft_q[8],
                  soft_q[2] | soft_q[3],
                  soft_q[5] | soft_q[6],
                  soft_q[1],
                  ext_flag[1],
                  soft_q[0],
                  ext_flag[0]};
    assign active = req & SRC_ENABLE & {12{GLOBAL_GATE}};

    tlic_prio_pick u_pick_hi (
        .req (active & PRIO_HIGH),
        .any (any_hi),
        .idx (idx_hi)
    );
    tlic_prio_pick u_pick_lo (
        .req (active & ~PRIO_HIGH),
        .any (any_lo),
        .idx (idx_lo)
    );

    // polled fresh every machine cycle, nothing pending is latched
    assign may_vector = p_last && (state_q == tlic_pkg::ST_IDLE) && LAST_CYCLE
                      && !CFG_WRITE && !EXIT_OP;
    assign pfi_take  = may_vector && POWER_FAIL_REQ && !ins_hi_q;
    assign hi_take   = may_vector && any_hi && !ins_hi_q;
    assign lo_take   = may_vector && any_lo && !ins_hi_q && !ins_lo_q;
    assign poll_take = pfi_take || hi_take || lo_take;
    assign sel       = hi_take ? idx_hi : idx_lo;
    assign sel_is_hi = pfi_take || hi_take;
    assign vec_d     = pfi_take ? PFAIL_VECTOR : tlic_pkg::VEC_TABLE[sel];
    assign exit_now  = p_last && LAST_CYCLE && EXIT_OP;

    ////////////////////////////////////////////////////////////////////////////
    // machine cycle phase
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            phase_q <= tlic_pkg::PHASE_RESET;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end

    // hardware call: four machine cycles, pc pushed low then high, then loaded
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            state_q    <= tlic_pkg::ST_IDLE;
            call_mc_q  <= 2'h0;
            call_act_q <= 1'b0;
            vec_q      <= tlic_pkg::VEC_RESET;
        end else begin
            unique case (state_q)
                tlic_pkg::ST_IDLE: begin
                    if (poll_take) begin
                        state_q    <= tlic_pkg::ST_CALL;
                        call_mc_q  <= 2'h0;
                        call_act_q <= 1'b1;
                        vec_q      <= vec_d;
                    end
                end
                tlic_pkg::ST_CALL: begin
                    if (call_end) begin
                        state_q    <= tlic_pkg::ST_IDLE;
                        call_act_q <= 1'b0;
                    end else if (p_last) begin
                        call_mc_q  <= call_mc_q + 2'h1;
                    end
                end
            endcase
        end
    end

    // status word is not saved: only pc pushes are strobed
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            push_lo_q <= 1'b0;
            push_hi_q <= 1'b0;
            pc_load_q <= 1'b0;
        end else begin
            push_lo_q <= (state_q == tlic_pkg::ST_CALL) && p_last && (call_mc_q == 2'h0);
            push_hi_q <= (state_q == tlic_pkg::ST_CALL) && p_last && (call_mc_q == 2'h1);
            pc_load_q <= call_end;
        end
    end

    // in-service per level; exit ends the highest active one
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            ins_hi_q <= 1'b0;
            ins_lo_q <= 1'b0;
        end else begin
            ins_hi_q <= (poll_take && sel_is_hi) || (ins_hi_q && !exit_now);
            ins_lo_q <= (poll_take && !sel_is_hi) || (ins_lo_q && !(exit_now && !ins_hi_q));
        end
    end

    assign MC_PHASE      = phase_q;
    assign CALL_ACTIVE   = call_act_q;
    assign PUSH_LOW      = push_lo_q;
    assign PUSH_HIGH     = push_hi_q;
    assign PC_LOAD       = pc_load_q;
    assign VEC_ADDR      = vec_q;
    assign IN_SERVICE_HI = ins_hi_q;
    assign IN_SERVICE_LO = ins_lo_q;

    ////////////////////////////////////////////////////////////////////////////
    sequence s_call_steps;
        ##5 PUSH_LOW ##4 PUSH_HIGH ##8 PC_LOAD;
    endsequence

    a_call_sequence: assert property (@(posedge MCLK) disable iff (!RSTN)
        poll_take |-> s_call_steps) else $error("call strobes off schedule");

    a_call_busy: assert property (@(posedge MCLK) disable iff (!RSTN)
        poll_take |=> CALL_ACTIVE[*8]) else $error("call ended early");

    a_vector_addr: assert property (@(posedge MCLK) disable iff (!RSTN)
        poll_take && !pfi_take && (sel == tlic_pkg::SRC_WDOG) |=> VEC_ADDR == 16'h0063)
        else $error("wrong watchdog vector");

    a_no_preempt: assert property (@(posedge MCLK) disable iff (!RSTN)
        $rose(IN_SERVICE_LO) |-> !$past(IN_SERVICE_HI)) else $error("low entered under high");

    a_gate_masks: assert property (@(posedge MCLK) disable iff (!RSTN)
        $rose(CALL_ACTIVE) |-> $past(GLOBAL_GATE) || $past(POWER_FAIL_REQ))
        else $error("vector taken with gate closed");

    a_timer_clear: assert property (@(posedge MCLK) disable iff (!RSTN)
        poll_take && !pfi_take && (sel == tlic_pkg::SRC_TF0) && !FLAG_WR |=> !FLAGS[tlic_pkg::FLG_TF0])
        else $error("timer0 flag not cleared");

    a_serial_kept: assert property (@(posedge MCLK) disable iff (!RSTN)
        poll_take && (sel == tlic_pkg::SRC_SER0) && FLAGS[tlic_pkg::FLG_RX0] |=> FLAGS[tlic_pkg::FLG_RX0] || $past(FLAG_WR))
        else $error("serial flag cleared by hardware");

    a_exit_clears: assert property (@(posedge MCLK) disable iff (!RSTN)
        exit_now && IN_SERVICE_HI && !poll_take |=> !IN_SERVICE_HI) else $error("exit left high level");

    a_level_ext0: assert property (@(posedge MCLK) disable iff (!RSTN)
        p_three && !EXT0_EDGE && !EXT_PIN[0] |=> FLAGS[tlic_pkg::FLG_EXT0]) else $error("level request lost");
endmodule // tlic_ctrl

/* File: rtl/tlic_ext_flag.sv */
// one external request pin: sampler, edge detector and request flag
`timescale 1ns/1ps
module tlic_ext_flag (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // pin and sampling
    input  wire logic pin,
    input  wire logic sample_en,
    input  wire logic edge_mode,
    // flag control
    input  wire logic hw_clear,
    input  wire logic sw_wr,
    input  wire logic sw_val,
    output logic      flag_q
);
    logic prev_q;
    logic flag_d;
    wire  fell;

    assign fell = sample_en & prev_q & ~pin;

    // set wins over every clear; level mode follows the low pin each sample
    assign flag_d = edge_mode ? (fell | (sw_wr ? sw_val : (flag_q & ~hw_clear)))
                  : sample_en ? (~pin | (sw_wr & sw_val))
                  : (sw_wr ? sw_val : flag_q);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q <= tlic_pkg::SAMPLE_RESET;
            flag_q <= tlic_pkg::FLAG_RESET;
        end else begin
            if (sample_en) begin
                prev_q <= pin;
            end
            flag_q <= flag_d;
        end
    end
endmodule // tlic_ext_flag

/* File: rtl/tlic_pkg.sv */
// shared constants and types of the two-level interrupt controller
package tlic_pkg;

    localparam int NUM_SRC  = 12;
    localparam int NUM_FLAG = 15;
    localparam int NUM_SOFT = 9;

    // machine cycle of four clocks, phases C1..C4 coded 0..3
    localparam int         CLKS_PER_MC   = 4;
    localparam logic [1:0] PHASE_THREE   = 2'h2;
    localparam logic [1:0] PHASE_LAST    = 2'h3;
    localparam logic [1:0] PHASE_RESET   = 2'h0;
    localparam logic [1:0] CALL_MC_LAST  = 2'h3;
    localparam int         CALL_MCYCLES  = 4;
    localparam int         MIN_LATENCY_MC = 5;
    localparam int         MAX_LATENCY_MC = 12;
    localparam int         MAX_LATENCY_CLK = MAX_LATENCY_MC * CLKS_PER_MC;

    // source index, table order is also the tie-break order
    localparam logic [3:0] SRC_EXT0 = 4'h0;
    localparam logic [3:0] SRC_TF0  = 4'h1;
    localparam logic [3:0] SRC_EXT1 = 4'h2;
    localparam logic [3:0] SRC_TF1  = 4'h3;
    localparam logic [3:0] SRC_SER0 = 4'h4;
    localparam logic [3:0] SRC_TMR2 = 4'h5;
    localparam logic [3:0] SRC_SER1 = 4'h6;
    localparam logic [3:0] SRC_EXT2 = 4'h7;
    localparam logic [3:0] SRC_WDOG = 4'hB;

    // flag index for the software write port and the flag bus
    localparam logic [3:0] FLG_EXT0 = 4'h0;
    localparam logic [3:0] FLG_EXT1 = 4'h1;
    localparam logic [3:0] FLG_EXT2 = 4'h2;
    localparam logic [3:0] FLG_TF0  = 4'h6;
    localparam logic [3:0] FLG_TF1  = 4'h7;
    localparam logic [3:0] FLG_TF2  = 4'h8;
    localparam logic [3:0] FLG_TIMER2_EXTERNAL_FLAG = 4'h9;
    localparam logic [3:0] FLG_WD   = 4'hA;
    localparam logic [3:0] FLG_RX0  = 4'hB;
    localparam logic [3:0] FLG_TX0  = 4'hC;
    localparam logic [3:0] FLG_RX1  = 4'hD;
    localparam logic [3:0] FLG_TX1  = 4'hE;

    localparam logic       FLAG_RESET   = 1'b0;
    localparam logic       SAMPLE_RESET = 1'b1;
    localparam logic [15:0] VEC_RESET   = 16'h0000;

    localparam logic [15:0] VEC_TABLE [0:11] = '{
        16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B,
        16'h003B, 16'h0043, 16'h004B, 16'h0053, 16'h005B, 16'h0063
    };

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_CALL = 1'b1
    } tlic_state_t;

endpackage

/* File: rtl/tlic_prio_pick.sv */
// fixed-order pick of the first request in a group
`timescale 1ns/1ps
module tlic_prio_pick (
    // requests, bit 0 is served first
    input  wire logic [11:0] req,
    // result
    output logic             any,
    output logic [3:0]       idx
);
    assign any = |req;

    always_comb begin
        idx = 4'h0;
        for (int i = tlic_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = 4'(i);
            end
        end
    end
endmodule // tlic_prio_pick

/* File: tb/testbench.sv */
// self-checking bench of the two-level interrupt controller
`timescale 1ns/1ps
module testbench;
    logic        mclk, rstn, pfail, gate, e0_edge, e1_edge, fwr, fval, stall, cfg, exit_req;
    logic        last_c, cfg_w, exit_op, call_act, push_l, push_h, pc_ld, ins_hi, ins_lo, exp_hi, exp_lo;
    logic [5:0]  ext_pin;
    logic [8:0]  ev;
    logic [11:0] src_en, prio, r_req;
    logic [3:0]  auto_clr, fsel;
    logic [1:0]  phase;
    logic [15:0] vec, pc;
    logic [14:0] flags, exp_f;
    logic [31:0] rnd;
    int          sp, num_errors, comparisons, w, s;
    localparam logic [15:0] PF_VEC = 16'h0033;
    localparam logic [15:0] VECS [12] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B,
                                          16'h003B, 16'h0043, 16'h004B, 16'h0053, 16'h005B, 16'h0063};
    localparam logic [14:0] SMASK [12] = '{15'h0001, 15'h0040, 15'h0002, 15'h0080, 15'h1800, 15'h0300,
                                           15'h6000, 15'h0004, 15'h0008, 15'h0010, 15'h0020, 15'h0400};

    tlic_ctrl #(.PFAIL_VECTOR(PF_VEC)) tlic_ctrl_inst (
        .MCLK(mclk), .RSTN(rstn), .EXT_PIN(ext_pin), .TF0_OVF(ev[0]), .TF1_OVF(ev[1]), .TF2_OVF(ev[2]),
        .TIMER2_EXTERNAL_FLAG_EVT(ev[3]), .WD_TIMEOUT(ev[4]), .RX0_DONE(ev[5]), .TX0_DONE(ev[6]), .RX1_DONE(ev[7]),
        .TX1_DONE(ev[8]), .POWER_FAIL_REQ(pfail), .SRC_ENABLE(src_en), .GLOBAL_GATE(gate),
        .PRIO_HIGH(prio), .EXT0_EDGE(e0_edge), .EXT1_EDGE(e1_edge), .AUTO_CLEAR(auto_clr),
        .FLAG_WR(fwr), .FLAG_SEL(fsel), .FLAG_VAL(fval), .LAST_CYCLE(last_c), .CFG_WRITE(cfg_w),
        .EXIT_OP(exit_op), .MC_PHASE(phase), .CALL_ACTIVE(call_act), .PUSH_LOW(push_l), .PUSH_HIGH(push_h),
        .PC_LOAD(pc_ld), .VEC_ADDR(vec), .IN_SERVICE_HI(ins_hi), .IN_SERVICE_LO(ins_lo), .FLAGS(flags));

    tlic_core_model tlic_core_model_inst (
        .mclk(mclk), .rst_n(rstn), .mc_phase(phase), .push_low(push_l), .push_high(push_h),
        .pc_load(pc_ld), .vec_addr(vec), .stall(stall), .cfg(cfg), .exit_req(exit_req),
        .last_cycle_q(last_c), .cfg_write_q(cfg_w), .exit_op_q(exit_op), .pc_q(pc), .sp_q(sp));

    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic logic [11:0] req_of(input logic [14:0] f);
        req_of = {f[10], f[5:2], f[13] | f[14], f[8] | f[9], f[11] | f[12], f[7], f[1], f[6], f[0]};
    endfunction

    function automatic logic [14:0] hwmask(input int k);
        hwmask = (k == 1 || k == 3 || (k == 0 && e0_edge) || (k == 2 && e1_edge) ||
                  (k >= 7 && k <= 10 && auto_clr[2'(k - 7)])) ? SMASK[k] : 15'h0000;
    endfunction

    task automatic tick;
        @(posedge mclk);
        #2;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wflag(input int i, input logic v);
        tick;
        fwr = 1'b1;
        fsel = 4'(i);
        fval = v;
        tick;
        fwr = 1'b0;
        exp_f[i] = v;
    endtask

    task automatic quiet(input int n);
        repeat (n) begin
            tick;
            chk(call_act, 1'b0, "unexpected call");
        end
    endtask

    task automatic do_call(input logic [15:0] v, input logic hi, input logic [14:0] clr, output int wt);
        int s0;
        wt = 0;
        while (call_act !== 1'b1 && wt < 60) begin
            tick;
            wt++;
        end
        s0 = sp;
        exp_f &= ~clr;
        if (hi)
            exp_hi = 1'b1;
        else
            exp_lo = 1'b1;
        chk(vec, v, "vector");
        chk({ins_hi, ins_lo}, {exp_hi, exp_lo}, "in service");
        chk(flags, exp_f, "flags at entry");
        for (int k = 1; k <= 17; k++) begin
            tick;
            chk({push_l, push_h, pc_ld, call_act}, {k == 4, k == 8, k == 16, k < 16}, "call steps");
        end
        chk(pc, v, "pc load");
        chk(sp, s0 + 2, "stack push");
    endtask

    task automatic do_exit;
        int n;
        int s0;
        n = 0;
        s0 = sp;
        exit_req = 1'b1;
        while (exit_op !== 1'b1 && n < 10) begin
            tick;
            n++;
        end
        exit_req = 1'b0;
        while (exit_op !== 1'b0 && n < 20) begin
            tick;
            n++;
        end
        if (exp_hi)
            exp_hi = 1'b0;
        else
            exp_lo = 1'b0;
        chk({ins_hi, ins_lo}, {exp_hi, exp_lo}, "exit");
        chk(sp, s0 - 2, "stack pop");
        chk(flags, exp_f, "flags");
    endtask

    task automatic summarize;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    initial begin
        #2000000;
        num_errors++;
        summarize;
    end

    initial begin
        {pfail, gate, e0_edge, e1_edge, fwr, fval, stall, cfg, exit_req} = '0;
        {ev, src_en, prio, auto_clr, fsel, exp_f, exp_hi, exp_lo} = '0;
        ext_pin = 6'h3f;
        rnd = 32'h41ac_8d4c;
        num_errors = 0;
        comparisons = 0;
        rstn = 1'b0;
        repeat (5) @(posedge mclk);
        #2 rstn = 1'b1;
        tick;
        chk({call_act, ins_hi, ins_lo, flags}, '0, "reset");
        chk(phase, 2'h1, "phase after reset");
        // timer pulses outside phase three must be dropped
        repeat (4) if (phase !== 2'h1) tick;
        ev = 9'h003;
        tick;
        rnd = lfsr(rnd);
        ev = {rnd[6:0], 2'b11};
        chk(flags, exp_f, "off-phase pulse");
        tick;
        exp_f[14:6] = ev;
        ev = 9'h000;
        chk(flags, exp_f, "event flags");
        for (int j = 0; j < 15; j++) wflag(j, 1'b0);
        e0_edge = 1'b1;
        ext_pin = 6'b11_0100;
        repeat (8) tick;
        exp_f[3:0] = 4'b1011;
        chk(flags, exp_f, "pin sample");
        ext_pin = 6'h3f;
        repeat (8) tick;
        exp_f[1] = 1'b0;
        chk(flags, exp_f, "pin release");
        wflag(0, 1'b0);
        wflag(3, 1'b0);
        src_en = 12'h005;
        gate = 1'b1;
        ext_pin[0] = 1'b0;
        do_call(16'h0003, 1'b0, 15'h0001, w);
        chk(w >= 2 && w + 17 <= tlic_pkg::MAX_LATENCY_CLK, 1'b1, "latency");
        ext_pin[0] = 1'b1;
        do_exit;
        ext_pin[1] = 1'b0;
        exp_f[1] = 1'b1;
        do_call(16'h0013, 1'b0, 15'h0000, w);
        ext_pin[1] = 1'b1;
        exp_f[1] = 1'b0;
        do_exit;
        // stalled and config-writing instructions refuse, denied request is lost
        src_en = 12'h002;
        stall = 1'b1;
        quiet(4);
        wflag(6, 1'b1);
        quiet(12);
        stall = 1'b0;
        cfg = 1'b1;
        quiet(12);
        wflag(6, 1'b0);
        cfg = 1'b0;
        quiet(12);
        gate = 1'b0;
        src_en = 12'h000;
        pfail = 1'b1;
        do_call(PF_VEC, 1'b1, 15'h0000, w);
        pfail = 1'b0;
        do_exit;
        // round 0 serves every source in tie order, later rounds are random
        for (int r = 0; r < 4; r++) begin
            rnd = lfsr(rnd);
            e1_edge = 1'b1;
            src_en = (r == 0) ? 12'hfff : rnd[11:0];
            prio = (r == 0) ? 12'h000 : rnd[23:12];
            auto_clr = (r == 0) ? 4'h5 : rnd[27:24];
            rnd = lfsr(rnd);
            for (int j = 0; j < 15; j++) wflag(j, (r == 0) | rnd[j]);
            gate = 1'b1;
            for (int n = 0; n < 13; n++) begin
                r_req = req_of(exp_f) & src_en;
                s = -1;
                for (int k = 11; k >= 0; k--) begin
                    if (((r_req & prio) != 0) ? (r_req[k] & prio[k]) : r_req[k])
                        s = k;
                end
                if (s < 0)
                    break;
                do_call(VECS[s], prio[s], hwmask(s), w);
                quiet(8);
                for (int j = 0; j < 15; j++) if (SMASK[s][j] && exp_f[j]) wflag(j, 1'b0);
                do_exit;
            end
            quiet(12);
            gate = 1'b0;
            for (int j = 0; j < 15; j++) if (exp_f[j]) wflag(j, 1'b0);
        end
        summarize;
    end
endmodule // testbench

/* File: tb/tlic_core_model.sv */
// core sequencer model: instruction boundaries, stack pushes and service exit
`timescale 1ns/1ps
module tlic_core_model (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // controller side
    input  wire logic [1:0]  mc_phase,
    input  wire logic        push_low,
    input  wire logic        push_high,
    input  wire logic        pc_load,
    input  wire logic [15:0] vec_addr,
    // bench controls
    input  wire logic        stall,
    input  wire logic        cfg,
    input  wire logic        exit_req,
    // sequencer status
    output logic             last_cycle_q,
    output logic             cfg_write_q,
    output logic             exit_op_q,
    output logic [15:0]      pc_q,
    output int               sp_q
);
    logic [7:0] stack_q [0:15];
    logic       bnd;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            last_cycle_q = 1'b1;
            cfg_write_q  = 1'b0;
            exit_op_q    = 1'b0;
            pc_q         = 16'h0100;
            sp_q         = 0;
        end else begin
            bnd = (mc_phase == 2'h3);
            // only the return address is stacked, low byte first
            if (push_low || push_high) begin
                stack_q[sp_q[3:0]] = push_low ? pc_q[7:0] : pc_q[15:8];
                sp_q++;
            end
            if (pc_load)
                pc_q = vec_addr;
            if (bnd && exit_op_q && last_cycle_q) begin
                pc_q = {stack_q[4'(sp_q - 1)], stack_q[4'(sp_q - 2)]};
                sp_q -= 2;
            end
            #1;
            // a stall stretches the instruction, so no boundary for polling
            if (bnd) begin
                last_cycle_q = !stall;
                cfg_write_q  = cfg;
                exit_op_q    = exit_req & !stall;
            end
        end
    end
endmodule // tlic_core_model
